/* logic/adc_conv_control.sv */
`timescale 1ns/1ps
// What this block does
// [RULE_01] with offset enabled, add the offset value to each raw code
// [RULE_02] with gain enabled, multiply the code by the gain value
// [RULE_03] each correction has its own enable; a disabled value has no effect
// [RULE_04] with both enabled, result is raw plus offset, then times gain
// [RULE_05] carry overflow bits; saturate only the final corrected value
// [RULE_06] offset is 24-bit two's complement; bits 23..8 are added
// [RULE_07] low byte of the offset is taken as zero
// [RULE_08] offset added by a 16-bit signed adder with no latency
// [RULE_09] offset enable or value change only affects the next result
// [RULE_10] gain is unsigned 24-bit; bits 23..8 over 32768 form the multiplier
// [RULE_11] low byte of the gain is taken as zero
// [RULE_12] gain uses add-and-shift on modulator clock, data ready 15 periods later
// [RULE_13] gain latency never delays the following conversion
// [RULE_14] gain enable or value change only affects the next result
// [RULE_15] single channel, mode 0x: one conversion then shutdown, field 0x
// [RULE_16] single channel, mode 10: one conversion then standby, field 10
// [RULE_17] sequenced, mode 0x or 10: one full cycle, then shutdown or standby
// [RULE_18] mode 11: continuous conversions or delayed repeated cycles, field stays 11
// [RULE_19] one-shot lasts one conversion time, two with chopping
// [RULE_20] one-shot data ready holds until the host reads the result
// [RULE_21] continuous single channel never stops or resets the filter
// [RULE_22] continuous: first data ready after one conversion time, then data rate
// [RULE_23] chopping turns continuous into back-to-back one-shots with reset
// [RULE_24] state field: 11 converting, 10 standby, 0x shutdown
// [RULE_25] leaving shutdown runs a 256 period start-up count before converting
// [RULE_26] clamp a final value outside 16-bit signed range to full scale
module adc_conv_control
  import adc_conv_pkg::*;
#(
  parameter int DIV                = 4,
  parameter int CONV_PERIODS       = 64,
  parameter int DR_PERIODS         = 32,
  parameter int SCAN_DELAY_PERIODS = 48
)(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // register port
  input  wire logic [3:0]  regAddr,
  input  wire logic        regWr,
  input  wire logic [23:0] regWrData,
  input  wire logic        regRd,
  output logic      [23:0] regRdData,
  // configuration bits
  input  wire logic        offsetCorrEnable,
  input  wire logic        gainCorrEnable,
  input  wire logic [1:0]  conversionModeSelect,
  input  wire logic        autoZeroChopping,
  input  wire logic        singleChannelMode,
  input  wire logic [3:0]  scanLength,
  input  wire logic        modeWr,
  input  wire logic [1:0]  modeWrData,
  // decimation filter side
  input  wire logic [15:0] rawCode,
  output logic             filterClear,
  output logic             convActive,
  // status
  output logic      [1:0]  converterState,
  output logic             irqN
);
  localparam int PW = RAW_W + 1 + RAW_W;

  conv_state_t          state_q;
  conv_state_t          target_q;
  logic [8:0]           startCnt_q;
  logic [23:0]          convCnt_q;
  logic [23:0]          delayCnt_q;
  logic [3:0]           chanCnt_q;
  logic                 firstDone_q;
  logic [23:0]          offset_q;
  logic [23:0]          gain_q;
  logic [15:0]          result_q;
  logic                 modEn;
  logic                 contMode;
  logic                 freeRun;
  logic                 lastInCycle;
  logic [23:0]          convLimit;
  logic                 eoc;
  logic signed [16:0]   sum;
  logic                 mulStart;
  logic                 mulBusy;
  logic                 mulDone;
  logic signed [PW-1:0] product;
  logic                 storeEv;
  logic [15:0]          storeVal;

  if (CONV_PERIODS <= GAIN_LATENCY_PERIODS || DR_PERIODS <= GAIN_LATENCY_PERIODS ||
      SCAN_DELAY_PERIODS < 1) begin : g_chk
    $error("conversion and data rate periods must exceed the gain latency");
  end

  // clamp an extended value to the 16-bit signed range
  function automatic logic [15:0] sat16(input logic signed [17:0] v);
    if (v > $signed(18'h0_7FFF)) begin
      return 16'h7FFF;
    end else if (v < $signed(18'h3_8000)) begin
      return 16'h8000;
    end else begin
      return v[15:0];
    end
  endfunction

  mod_clock_divider #(.DIV(DIV)) u_div (
    .mclk  (mclk),
    .rst   (rst),
    .modEn (modEn)
  );

  // mode decode and end of conversion timing
  assign contMode    = (conversionModeSelect == MODE_CONVERT);
  assign freeRun     = contMode && singleChannelMode && !autoZeroChopping;  // [RULE_21]
  assign lastInCycle = singleChannelMode || (chanCnt_q + 4'h1 >= scanLength);
  always_comb begin
    if (freeRun && firstDone_q) begin
      convLimit = 24'(DR_PERIODS);  // [RULE_22]
    end else if (autoZeroChopping) begin
      convLimit = 24'(2 * CONV_PERIODS);  // [RULE_19] [RULE_23]
    end else begin
      convLimit = 24'(CONV_PERIODS);  // [RULE_19]
    end
  end
  assign eoc = (state_q == ST_CONVERT) && modEn && (convCnt_q == convLimit - 24'h00_0001);

  // conversion sequencer and start-up timer
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q        <= ST_SHUTDOWN;
      target_q       <= ST_STANDBY;
      converterState <= MODE_SHUTDOWN;
      startCnt_q     <= 9'(STARTUP_PERIODS);
      convCnt_q      <= '0;
      delayCnt_q     <= '0;
      chanCnt_q      <= '0;
      firstDone_q    <= 1'b0;
      filterClear    <= 1'b0;
    end else begin
      filterClear <= 1'b0;
      if (modeWr && !modeWrData[1]) begin
        state_q        <= ST_SHUTDOWN;  // [RULE_24]
        converterState <= MODE_SHUTDOWN;
        startCnt_q     <= 9'(STARTUP_PERIODS);
      end else if (modeWr && state_q == ST_SHUTDOWN) begin
        state_q        <= ST_STARTUP;  // [RULE_25]
        target_q       <= modeWrData[0] ? ST_CONVERT : ST_STANDBY;
        converterState <= modeWrData;
      end else if (modeWr && state_q == ST_STARTUP) begin
        target_q       <= modeWrData[0] ? ST_CONVERT : ST_STANDBY;
        converterState <= modeWrData;
      end else if (modeWr && modeWrData[0] && state_q == ST_STANDBY) begin
        state_q        <= ST_CONVERT;
        converterState <= MODE_CONVERT;
        convCnt_q      <= '0;
        chanCnt_q      <= '0;
        firstDone_q    <= 1'b0;
        filterClear    <= 1'b1;
      end else if (modeWr && !modeWrData[0] && state_q != ST_STANDBY) begin
        state_q        <= ST_STANDBY;
        converterState <= MODE_STANDBY;
      end else begin
        unique case (state_q)
          ST_STARTUP: begin
            if (modEn) begin
              startCnt_q <= startCnt_q - 9'h001;  // [RULE_25]
              if (startCnt_q == 9'h001) begin
                state_q     <= target_q;
                convCnt_q   <= '0;
                chanCnt_q   <= '0;
                firstDone_q <= 1'b0;
                filterClear <= (target_q == ST_CONVERT);
              end
            end
          end
          ST_CONVERT: begin
            if (eoc) begin
              convCnt_q <= '0;  // [RULE_13]
              if (!lastInCycle) begin
                chanCnt_q   <= chanCnt_q + 4'h1;
                filterClear <= 1'b1;
              end else if (contMode && !singleChannelMode) begin
                state_q    <= ST_DELAY;  // [RULE_18]
                delayCnt_q <= '0;
              end else if (contMode) begin
                firstDone_q <= 1'b1;
                filterClear <= autoZeroChopping;  // [RULE_21] [RULE_23]
              end else if (conversionModeSelect[1]) begin
                state_q        <= ST_STANDBY;  // [RULE_16] [RULE_17]
                converterState <= MODE_STANDBY;
                chanCnt_q      <= '0;
              end else begin
                state_q        <= ST_SHUTDOWN;  // [RULE_15] [RULE_17]
                converterState <= MODE_SHUTDOWN;
                startCnt_q     <= 9'(STARTUP_PERIODS);
                chanCnt_q      <= '0;
              end
            end else if (modEn) begin
              convCnt_q <= convCnt_q + 24'h00_0001;
            end
          end
          ST_DELAY: begin
            if (modEn) begin
              delayCnt_q <= delayCnt_q + 24'h00_0001;
              if (delayCnt_q == 24'(SCAN_DELAY_PERIODS - 1)) begin
                state_q     <= ST_CONVERT;  // [RULE_18]
                convCnt_q   <= '0;
                chanCnt_q   <= '0;
                filterClear <= 1'b1;
              end
            end
          end
          ST_SHUTDOWN, ST_STANDBY: begin
          end
        endcase
      end
    end
  end

  // converting indicator
  always_ff @(posedge mclk) begin
    if (rst) begin
      convActive <= 1'b0;
    end else begin
      convActive <= (state_q == ST_CONVERT);
    end
  end

  // offset sum with one extra overflow bit, low byte of offset dropped
  assign sum = $signed({rawCode[15], rawCode}) +                             // [RULE_08]
               (offsetCorrEnable ? $signed({offset_q[23], offset_q[23:CAL_LSB]})  // [RULE_01] [RULE_03]
                                 : 17'sh0_0000);                             // [RULE_06] [RULE_07]
  assign mulStart = eoc && gainCorrEnable;  // [RULE_02] [RULE_04]

  gain_shift_multiplier #(.SUM_W(RAW_W + 1), .GAIN_W(RAW_W)) u_mul (
    .mclk    (mclk),
    .rst     (rst),
    .tick    (modEn),
    .start   (mulStart),
    .sumIn   (sum),
    .gainIn  (gain_q[23:CAL_LSB]),  // [RULE_10] [RULE_11]
    .busy    (mulBusy),
    .done    (mulDone),
    .product (product)
  );

  // select the value to store; saturation only on the final value
  assign storeEv = (eoc && !gainCorrEnable) || mulDone;  // [RULE_12]
  always_comb begin
    if (mulDone) begin
      storeVal = sat16(product[PW-1:15]);  // [RULE_05] [RULE_26]
    end else begin
      storeVal = sat16({sum[16], sum});  // [RULE_26]
    end
  end

  // result register, only rewritten with a data ready
  always_ff @(posedge mclk) begin
    if (rst) begin
      result_q <= RESULT_RESET;
    end else if (storeEv) begin
      result_q <= storeVal;  // [RULE_09] [RULE_14]
    end
  end

  // data ready line: a new result wins over a clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      irqN <= 1'b1;
    end else if (storeEv) begin
      irqN <= 1'b0;
    end else if (regRd && regAddr == RESULT_ADDR) begin
      irqN <= 1'b1;  // [RULE_20]
    end else if (modEn && contMode) begin
      irqN <= 1'b1;
    end
  end

  // calibration registers and read data
  always_ff @(posedge mclk) begin
    if (rst) begin
      offset_q  <= OFFSET_RESET;
      gain_q    <= GAIN_RESET;
      regRdData <= '0;
    end else begin
      if (regWr && regAddr == OFFSET_ADDR) begin
        offset_q <= regWrData;
      end
      if (regWr && regAddr == GAIN_ADDR) begin
        gain_q <= regWrData;
      end
      if (regRd) begin
        unique case (regAddr)
          RESULT_ADDR: regRdData <= {8'h00, result_q};
          OFFSET_ADDR: regRdData <= offset_q;
          GAIN_ADDR:   regRdData <= gain_q;
          default:     regRdData <= '0;
        endcase
      end
    end
  end

  // helper: modulator ticks spent in the gain multiplier
  logic [4:0] gainTicks_q;
  always_ff @(posedge mclk) begin
    if (rst || mulStart) begin
      gainTicks_q <= '0;
    end else if (mulBusy && modEn) begin
      gainTicks_q <= gainTicks_q + 5'h01;
    end
  end

  property p_gain_latency;
    @(posedge mclk) disable iff (rst) mulDone |-> gainTicks_q == 5'(GAIN_LATENCY_PERIODS);
  endproperty
  a_gain_latency: assert property (p_gain_latency) else $error("gain latency wrong"); // [RULE_12]

  property p_offset_only;
    @(posedge mclk) disable iff (rst)
      (eoc && !gainCorrEnable && offsetCorrEnable)
        |=> result_q == $past(sat16(18'(signed'(rawCode)) + 18'(signed'(offset_q[23:CAL_LSB]))));
  endproperty
  a_offset_only: assert property (p_offset_only) else $error("offset result wrong"); // [RULE_01]

  property p_no_corr;
    @(posedge mclk) disable iff (rst)
      (eoc && !gainCorrEnable && !offsetCorrEnable) |=> result_q == $past(rawCode);
  endproperty
  a_no_corr: assert property (p_no_corr) else $error("uncorrected result wrong"); // [RULE_03]

  property p_offset_hold;
    @(posedge mclk) disable iff (rst)
      (regWr && regAddr == OFFSET_ADDR && !storeEv) |=> $stable(result_q);
  endproperty
  a_offset_hold: assert property (p_offset_hold) else $error("offset write moved result"); // [RULE_09]

  property p_gain_hold;
    @(posedge mclk) disable iff (rst)
      (regWr && regAddr == GAIN_ADDR && !storeEv) |=> $stable(result_q);
  endproperty
  a_gain_hold: assert property (p_gain_hold) else $error("gain write moved result"); // [RULE_14]

  property p_irq_hold;
    @(posedge mclk) disable iff (rst)
      (!irqN && !contMode && !(regRd && regAddr == RESULT_ADDR)) |=> !irqN;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("one-shot data ready dropped"); // [RULE_20]

  property p_oneshot_shutdown;
    @(posedge mclk) disable iff (rst)
      (eoc && lastInCycle && !modeWr && !conversionModeSelect[1])
        |=> state_q == ST_SHUTDOWN && converterState == MODE_SHUTDOWN;
  endproperty
  a_oneshot_shutdown: assert property (p_oneshot_shutdown) else $error("no shutdown"); // [RULE_15]

  property p_oneshot_standby;
    @(posedge mclk) disable iff (rst)
      (eoc && lastInCycle && !modeWr && conversionModeSelect == MODE_STANDBY)
        |=> state_q == ST_STANDBY && converterState == MODE_STANDBY;
  endproperty
  a_oneshot_standby: assert property (p_oneshot_standby) else $error("no standby"); // [RULE_16]

  property p_startup_done;
    @(posedge mclk) disable iff (rst)
      (state_q == ST_STARTUP ##1 state_q == ST_CONVERT) |-> $past(startCnt_q) == 9'h001;
  endproperty
  a_startup_done: assert property (p_startup_done) else $error("start-up cut short"); // [RULE_25]

  property p_state_code;
    @(posedge mclk) disable iff (rst) converterState != 2'b01;
  endproperty
  a_state_code: assert property (p_state_code) else $error("illegal state field"); // [RULE_24]

  c_gain_store: cover property (@(posedge mclk) disable iff (rst) mulDone);
  c_read_clear: cover property (@(posedge mclk) disable iff (rst) !irqN ##1 irqN && !contMode);
  c_scan_delay: cover property (@(posedge mclk) disable iff (rst) state_q == ST_DELAY);
  c_free_run:   cover property (@(posedge mclk) disable iff (rst) eoc && freeRun && firstDone_q);
endmodule

/* logic/gain_shift_multiplier.sv */
`timescale 1ns/1ps
module gain_shift_multiplier #(
  parameter int SUM_W  = 17,
  parameter int GAIN_W = 16
)(
  // clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rst,
  input  wire logic                      tick,
  // operands
  input  wire logic                      start,
  input  wire logic signed [SUM_W-1:0]   sumIn,
  input  wire logic [GAIN_W-1:0]         gainIn,
  // result
  output logic                           busy,
  output logic                           done,
  output logic signed [SUM_W+GAIN_W-1:0] product
);
  localparam int PW = SUM_W + GAIN_W;
  localparam int SW = $clog2(GAIN_W);

  logic signed [PW-1:0] mcand_q;
  logic [GAIN_W-1:0]    mult_q;
  logic [SW-1:0]        steps_q;

  if (GAIN_W < 2) begin : g_chk
    $error("gain width must be at least 2");
  end

  // bit 0 is added at start, then one bit per tick: GAIN_W-1 ticks in all
  always_ff @(posedge mclk) begin
    if (rst) begin
      busy    <= 1'b0;
      done    <= 1'b0;
      product <= '0;
      mcand_q <= '0;
      mult_q  <= '0;
      steps_q <= '0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy    <= 1'b1;
        product <= gainIn[0] ? PW'(sumIn) : '0;
        mcand_q <= PW'(sumIn) <<< 1;
        mult_q  <= gainIn >> 1;
        steps_q <= SW'(GAIN_W - 1);
      end else if (busy && tick) begin
        if (mult_q[0]) begin
          product <= product + mcand_q;
        end
        mcand_q <= mcand_q <<< 1;
        mult_q  <= mult_q >> 1;
        steps_q <= steps_q - 1'b1;
        if (steps_q == SW'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule

/* logic/mod_clock_divider.sv */
`timescale 1ns/1ps
module mod_clock_divider #(
  parameter int DIV = 4
)(
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // modulator clock enable, one pulse every DIV cycles
  output logic      modEn
);
  localparam int CW = $clog2(DIV);

  logic [CW-1:0] cnt_q;

  if (DIV < 2) begin : g_chk
    $error("divider ratio must be at least 2");
  end

  // free running divider of the master clock
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_q <= '0;
      modEn <= 1'b0;
    end else if (cnt_q == CW'(DIV - 1)) begin
      cnt_q <= '0;
      modEn <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      modEn <= 1'b0;
    end
  end
endmodule

/* shared/adc_conv_pkg.sv */
package adc_conv_pkg;

  // register offsets
  localparam logic [3:0] RESULT_ADDR = 4'h0;
  localparam logic [3:0] OFFSET_ADDR = 4'h9;
  localparam logic [3:0] GAIN_ADDR   = 4'hA;

  // widths and field layout of the calibration registers
  localparam int RAW_W   = 16;
  localparam int CAL_W   = 24;
  localparam int CAL_LSB = 8;  // low byte is ignored by both corrections

  // reset values
  localparam logic [23:0] OFFSET_RESET = 24'h00_0000;
  localparam logic [23:0] GAIN_RESET   = 24'h80_0000;  // unity multiplier
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  // timing counts in modulator clock periods
  localparam int STARTUP_PERIODS      = 256;
  localparam int GAIN_LATENCY_PERIODS = 15;

  // converter state field encodings
  localparam logic [1:0] MODE_SHUTDOWN = 2'b00;
  localparam logic [1:0] MODE_STANDBY  = 2'b10;
  localparam logic [1:0] MODE_CONVERT  = 2'b11;

  // converter sequencing states, gray along shutdown-startup-convert-delay
  typedef enum logic [2:0] {
    ST_SHUTDOWN = 3'b000,
    ST_STARTUP  = 3'b001,
    ST_CONVERT  = 3'b011,
    ST_DELAY    = 3'b010,
    ST_STANDBY  = 3'b110
  } conv_state_t;

endpackage

/* tb/adc_conv_control_tb.sv */
`timescale 1ns/1ps
module adc_conv_control_tb
  import adc_conv_pkg::*;
;
  logic        mclk, regWr, regRd, filterClear, convActive, irqN;
  logic        rst = 1'b1, modeWr = 1'b0, offsetCorrEnable = 1'b0, gainCorrEnable = 1'b0;
  logic        autoZeroChopping = 1'b0, singleChannelMode = 1'b1, autoRead = 1'b0;
  logic [3:0]  regAddr, scanLength = 4'h1, readLag = 4'h0;
  logic [23:0] regWrData, regRdData;
  logic [1:0]  conversionModeSelect = MODE_STANDBY, modeWrData = 2'b00, converterState;
  logic [15:0] rawCode = 16'h0000;
  int          fails = 0, numChecks = 0, clears = 0, n, m;

  // converter control with shortened counts
  adc_conv_control #(.DIV(2), .CONV_PERIODS(20), .DR_PERIODS(16), .SCAN_DELAY_PERIODS(4)) dut_u (
    .mclk(mclk), .rst(rst), .regAddr(regAddr), .regWr(regWr), .regWrData(regWrData), .regRd(regRd),
    .regRdData(regRdData), .offsetCorrEnable(offsetCorrEnable), .gainCorrEnable(gainCorrEnable),
    .conversionModeSelect(conversionModeSelect), .autoZeroChopping(autoZeroChopping),
    .singleChannelMode(singleChannelMode), .scanLength(scanLength), .modeWr(modeWr),
    .modeWrData(modeWrData), .rawCode(rawCode), .filterClear(filterClear), .convActive(convActive),
    .converterState(converterState), .irqN(irqN));

  // host controller on the register port
  host_ctrl_model host_u (.mclk(mclk), .regAddr(regAddr), .regWr(regWr), .regWrData(regWrData),
    .regRd(regRd), .regRdData(regRdData), .irqN(irqN), .autoRead(autoRead), .readLag(readLag));

  // 200 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // counts filter clear pulses
  always @(posedge mclk) if (filterClear === 1'b1) clears++;

  // expected corrected and clamped result
  function automatic logic [15:0] corrected(input logic [15:0] raw, input logic [23:0] off,
                                            input logic [23:0] gain, input logic eo, input logic eg);
    logic signed [40:0] v;
    v = $signed(raw);
    if (eo) v = v + $signed(off[23:8]);
    if (eg) v = (v * $signed({1'b0, gain[23:8]})) >>> 15;
    if (v > 32767) return 16'h7FFF;
    if (v < -32768) return 16'h8000;
    return v[15:0];
  endfunction

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    numChecks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one settled cycle
  task automatic step(inout int k);
    @(posedge mclk);
    #1;
    k++;
  endtask

  // cycles until the next data ready
  task automatic wait_irq(output int k);
    k = 0;
    while (irqN !== 1'b1 && k < 3000) step(k);
    while (irqN !== 1'b0 && k < 3000) step(k);
    if (k >= 3000) fails++;
  endtask

  task automatic set_mode(input logic [1:0] md);
    @(posedge mclk);
    modeWr <= 1'b1;
    modeWrData <= md;
    @(posedge mclk);
    modeWr <= 1'b0;
  endtask

  task automatic rd_check(input logic [3:0] a, input logic [23:0] exp);
    host_u.access(a, 1'b0, 24'h00_0000);
    check(host_u.lastRd, exp);
  endtask

  // one single-channel one-shot from standby, result read and judged
  task automatic convert(input logic [15:0] raw, input logic [23:0] off, input logic [23:0] gain,
                         input logic eo, input logic eg, output int k);
    host_u.access(OFFSET_ADDR, 1'b1, off);
    host_u.access(GAIN_ADDR, 1'b1, gain);
    @(posedge mclk);
    rawCode <= raw;
    offsetCorrEnable <= eo;
    gainCorrEnable <= eg;
    set_mode(MODE_CONVERT);
    wait_irq(k);
    repeat (10) @(posedge mclk);
    check({23'h0, irqN}, 24'h0);
    rd_check(RESULT_ADDR, {8'h00, corrected(raw, off, gain, eo, eg)});
    check({23'h0, irqN}, 24'h1);
  endtask

  task automatic test_reset();
    check({22'h0, converterState}, {22'h0, MODE_SHUTDOWN});
    rd_check(OFFSET_ADDR, OFFSET_RESET);
    rd_check(GAIN_ADDR, GAIN_RESET);
    host_u.access(RESULT_ADDR, 1'b1, 24'hFF_FFFF);
    host_u.access(4'h5, 1'b1, 24'h12_3456);
    rd_check(RESULT_ADDR, 24'h00_0000);
    rd_check(4'h5, 24'h00_0000);
    $display("test reset finished");
  endtask

  task automatic test_startup();
    @(posedge mclk);
    rawCode <= 16'h1234;
    set_mode(MODE_CONVERT);
    n = 0;
    step(n);
    check({22'h0, converterState}, {22'h0, MODE_CONVERT});
    while (convActive !== 1'b1 && n < 1000) step(n);
    check({23'h0, (n inside {[512:520]})}, 24'h1);
    wait_irq(m);
    check({23'h0, (m inside {[38:44]})}, 24'h1);
    check({22'h0, converterState}, {22'h0, MODE_STANDBY});
    rd_check(RESULT_ADDR, 24'h00_1234);
    $display("test startup finished");
  endtask

  task automatic test_corrections();
    convert(16'h0100, 24'hFF_FEAB, GAIN_RESET, 1'b1, 1'b0, n);
    m = n;
    convert(16'h0100, 24'h00_0000, 24'h60_00FF, 1'b0, 1'b1, n);
    check({23'h0, ((n - m) inside {[30:31]})}, 24'h1);
    convert(16'hFFF0, 24'h00_10C3, 24'h90_0000, 1'b1, 1'b1, n);
    convert(16'h7000, 24'h20_0000, 24'h40_0000, 1'b1, 1'b1, n);
    convert(16'h8000, 24'hF0_0000, 24'h40_0000, 1'b1, 1'b1, n);
    convert(16'h7FFF, 24'h00_0100, GAIN_RESET, 1'b1, 1'b0, n);
    convert(16'h8000, 24'hFF_FF00, GAIN_RESET, 1'b1, 1'b0, n);
    @(posedge mclk);
    autoZeroChopping <= 1'b1;
    convert(16'h2222, 24'h7F_0000, 24'h12_3400, 1'b0, 1'b0, n);
    check({23'h0, ((n - m) inside {[38:42]})}, 24'h1);
    host_u.access(OFFSET_ADDR, 1'b1, 24'h01_0000);
    host_u.access(GAIN_ADDR, 1'b1, 24'h40_0000);
    @(posedge mclk);
    autoZeroChopping <= 1'b0;
    offsetCorrEnable <= 1'b1;
    gainCorrEnable <= 1'b1;
    repeat (8) @(posedge mclk);
    rd_check(RESULT_ADDR, 24'h00_2222);
    convert(16'h2222, 24'h01_0000, 24'h40_0000, 1'b1, 1'b1, n);
    $display("test corrections finished");
  endtask

  task automatic test_continuous();
    @(posedge mclk);
    conversionModeSelect <= MODE_CONVERT;
    set_mode(MODE_CONVERT);
    wait_irq(n);
    check({23'h0, (n inside {[68:76]})}, 24'h1);
    clears = 0;
    for (int i = 0; i < 3; i++) begin
      wait_irq(n);
      check(24'(n), 24'h00_0020);
    end
    check(24'(clears), 24'h00_0000);
    check({22'h0, converterState}, {22'h0, MODE_CONVERT});
    @(posedge mclk);
    autoZeroChopping <= 1'b1;
    wait_irq(n);
    wait_irq(n);
    wait_irq(n);
    check({23'h0, (n inside {[80:84]})}, 24'h1);
    check({23'h0, (clears > 0)}, 24'h1);
    @(posedge mclk);
    autoZeroChopping <= 1'b0;
    conversionModeSelect <= 2'b01;
    set_mode(MODE_STANDBY);
    host_u.access(RESULT_ADDR, 1'b0, 24'h00_0000);
    check({22'h0, converterState}, {22'h0, MODE_STANDBY});
    convert(16'h0042, 24'h00_0000, GAIN_RESET, 1'b0, 1'b0, n);
    check({22'h0, converterState}, {22'h0, MODE_SHUTDOWN});
    $display("test continuous finished");
  endtask

  task automatic test_scan();
    @(posedge mclk);
    singleChannelMode <= 1'b0;
    scanLength <= 4'h3;
    conversionModeSelect <= MODE_STANDBY;
    readLag <= 4'h3;
    autoRead <= 1'b1;
    host_u.numRd = 0;
    set_mode(MODE_CONVERT);
    n = 0;
    step(n);
    while (converterState !== MODE_STANDBY && n < 3000) step(n);
    repeat (12) step(n);
    check(24'(host_u.numRd), 24'h00_0003);
    @(posedge mclk);
    scanLength <= 4'h2;
    conversionModeSelect <= MODE_CONVERT;
    host_u.numRd = 0;
    set_mode(MODE_CONVERT);
    repeat (400) step(n);
    check({22'h0, converterState}, {22'h0, MODE_CONVERT});
    check({23'h0, (host_u.numRd >= 6)}, 24'h1);
    set_mode(MODE_SHUTDOWN);
    step(n);
    check({22'h0, converterState}, {22'h0, MODE_SHUTDOWN});
    $display("test scan finished");
  endtask

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", numChecks, fails);
    if (fails == 0 && numChecks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // watchdog well beyond the expected few thousand cycles
  initial begin
    repeat (40000) @(posedge mclk);
    fails++;
    complete_run();
  end

  // main sequence
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    step(n);
    test_reset();
    test_startup();
    test_corrections();
    test_continuous();
    test_scan();
    complete_run();
  end
endmodule

/* tb/host_ctrl_model.sv */
`timescale 1ns/1ps
module host_ctrl_model
  import adc_conv_pkg::*;
(
  // clock
  input  wire logic        mclk,
  // register port towards the converter
  output logic      [3:0]  regAddr,
  output logic             regWr,
  output logic      [23:0] regWrData,
  output logic             regRd,
  input  wire logic [23:0] regRdData,
  // data ready and read policy
  input  wire logic        irqN,
  input  wire logic        autoRead,
  input  wire logic [3:0]  readLag
);
  logic [23:0] lastRd;
  int          numRd = 0;

  // idle bus at time zero
  initial begin
    regAddr = 4'h0;
    regWr = 1'b0;
    regWrData = 24'h00_0000;
    regRd = 1'b0;
  end

  // one register access, strobe held for exactly one taken edge
  task automatic access(input logic [3:0] a, input logic wr, input logic [23:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWr <= wr;
    regWrData <= d;
    regRd <= !wr;
    @(posedge mclk);
    regWr <= 1'b0;
    regRd <= 1'b0;
    regWrData <= ~d;  // released data no longer shows the last value
    @(posedge mclk);
    if (!wr) lastRd = regRdData;
  endtask

  // reads the whole result after a data ready, promptly or after a lag
  always begin
    @(posedge mclk);
    if (autoRead && irqN === 1'b0) begin
      repeat (readLag) @(posedge mclk);
      access(RESULT_ADDR, 1'b0, 24'h00_0000);
      numRd++;
    end
  end
endmodule
